//--- core/rpd_detector.sv
// Rotor position detector with AXI4-Lite register port.
// Assumes timer events, PWM and low-side drive levels come from logic on aclk.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Emergency stop is enabled after reset; input held high or circuit disabled.
// - Ordinary mode: match with expected pattern raises interrupt and ends sampling.
// - Unmatch mode: capture inputs at start, interrupt when inputs differ.
// - Captured start state is readable in a status field.
// - Start by software or Timer 2; Timer 3 stops in timer-synchronous use.
// - Three sampling modes: PWM-on only, continuous, low-side conduction.
// - Low-side mode samples each phase from delay end until its current stops.
// - Idle phases keep last sample; retained plus live values form the match.
// - PWM-on and low-side modes wait a programmed delay after turn-on.
// - Match count restarts each PWM-on interval or counts on, selectable.
// - Expected patterns per rotor mode 0 to 5 follow the fixed table.
// - Detection needs the programmed number of consecutive compare hits.
// - Mode bit 0 selects match detection, 1 selects change detection.
// - With recount enabled outside continuous mode, the count clears whenever combined PWM turns off.
module rpd_detector
    import rpd_pkg::*;
(
    input  wire logic        aclk,                    // Block clock, 125 MHz.
    input  wire logic        aresetn,                 // Synchronous reset, active low.
    input  wire logic [7:0]  awaddr,                  // Write address.
    input  wire logic        awvalid,                 // Write address valid.
    output logic             awready,                 // Write address ready.
    input  wire logic [31:0] wdata,                   // Write data.
    input  wire logic [3:0]  wstrb,                   // Write byte strobes.
    input  wire logic        wvalid,                  // Write data valid.
    output logic             wready,                  // Write data ready.
    output logic [1:0]       bresp,                   // Write response.
    output logic             bvalid,                  // Write response valid.
    input  wire logic        bready,                  // Write response ready.
    input  wire logic [7:0]  araddr,                  // Read address.
    input  wire logic        arvalid,                 // Read address valid.
    output logic             arready,                 // Read address ready.
    output logic [31:0]      rdata,                   // Read data.
    output logic [1:0]       rresp,                   // Read response.
    output logic             rvalid,                  // Read data valid.
    input  wire logic        rready,                  // Read data ready.
    input  wire logic        phase_u_position_input,  // U position pin.
    input  wire logic        phase_v_position_input,  // V position pin.
    input  wire logic        phase_w_position_input,  // W position pin.
    input  wire logic        emergency_stop_input,    // Emergency pin, active low.
    input  wire logic        timer2_event,            // Timer 2 start pulse.
    input  wire logic        timer3_event,            // Timer 3 stop pulse.
    input  wire logic [2:0]  pwm_phase_on,            // PWM on per phase {U,V,W}.
    input  wire logic [2:0]  low_side_on,             // Low side conducting {U,V,W}.
    output logic             position_detect_interrupt, // One-cycle detect pulse.
    output logic             emergency_stop_active,   // Latched emergency stop.
    output logic             sampling_active          // Sampling under way.
);

    // ****************************************************************
    // Input synchronisation.
    // ****************************************************************
    logic [3:0] pins_s;
    logic [2:0] pos_s;
    logic       emg_s;

    // Pins are asynchronous to aclk, so they pass the filtered synchroniser.
    rpd_sync3 #(.WIDTH(4), .RST_VAL(4'h8)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_in   ({emergency_stop_input, phase_u_position_input,
                    phase_v_position_input, phase_w_position_input}),
        .sync_out (pins_s)
    );
    assign pos_s = pins_s[2:0];
    assign emg_s = pins_s[3];

    // ****************************************************************
    // AXI4-Lite slave and configuration registers.
    // ****************************************************************
    rpd_ctrl_a_t ctrl_a_q, ctrl_a_d;
    rpd_ctrl_b_t ctrl_b_q, ctrl_b_d;
    logic [2:0]  expect_q, expect_d;
    logic [7:0]  delay_q, delay_d;
    logic        emg_en_q, emg_en_d;
    logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [7:0]  waddr_q, waddr_d;
    logic [31:0] wdat_q, wdat_d;
    logic        wlane_q, wlane_d;
    logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic        arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic        sw_start, sw_stop, emg_clr;
    logic        wr_go;
    rpd_state_t  state_q, state_d;
    logic [2:0]  capture_q, capture_d;
    logic [2:0]  rot_idx;

    // Address and data are latched separately; the write lands once both are held.
    always_comb begin
        ctrl_a_d  = ctrl_a_q;
        ctrl_b_d  = ctrl_b_q;
        expect_d  = expect_q;
        delay_d   = delay_q;
        emg_en_d  = emg_en_q;
        waddr_d   = waddr_q;
        wdat_d    = wdat_q;
        wlane_d   = wlane_q;
        bresp_d   = bresp_q;
        bvalid_d  = bvalid_q && !bready;
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        sw_start  = 1'b0;
        sw_stop   = 1'b0;
        emg_clr   = 1'b0;
        rot_idx   = wdat_q[2:0];
        if (awvalid && awready_q) begin
            aw_hold_d = 1'b1;
            waddr_d   = awaddr;
        end
        if (wvalid && wready_q) begin
            w_hold_d = 1'b1;
            wdat_d   = wdata;
            wlane_d  = wstrb[0];
        end
        wr_go = aw_hold_q && w_hold_q && !bvalid_q;
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RPD_RESP_OKAY;
            unique case (waddr_q)
                RPD_OFS_CTRL_A: if (wlane_q) begin
                    ctrl_a_d = rpd_ctrl_a_t'(wdat_q[5:0]);
                    sw_start = wdat_q[RPD_BIT_SW_START];
                    sw_stop  = wdat_q[RPD_BIT_SW_STOP];
                end
                RPD_OFS_CTRL_B: if (wlane_q) ctrl_b_d = rpd_ctrl_b_t'(wdat_q[7:0]);
                RPD_OFS_STATUS: ;
                RPD_OFS_EXPECT: if (wlane_q) expect_d = wdat_q[2:0];
                RPD_OFS_DELAY:  if (wlane_q) delay_d = wdat_q[7:0];
                RPD_OFS_EMG: if (wlane_q) begin
                    emg_en_d = wdat_q[RPD_BIT_EMG_EN];
                    emg_clr  = wdat_q[RPD_BIT_EMG_CLR];
                end
                RPD_OFS_ROTOR: begin
                    // Out-of-range rotor modes leave the expected pattern alone.
                    if (wlane_q && rot_idx <= 3'd5) expect_d = RPD_PATTERN[rot_idx];
                end
                default: bresp_d = RPD_RESP_SLVERR;
            endcase
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d  = !w_hold_d && !bvalid_d;
    end

    // Read side: one read at a time, data registered with the response.
    always_comb begin
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        rvalid_d  = rvalid_q && !rready;
        arready_d = !rvalid_d;
        if (arvalid && arready_q) begin
            rvalid_d  = 1'b1;
            arready_d = 1'b0;
            rresp_d   = RPD_RESP_OKAY;
            rdata_d   = 32'h0000_0000;
            unique case (araddr)
                RPD_OFS_CTRL_A: rdata_d[5:0] = ctrl_a_q;
                RPD_OFS_CTRL_B: rdata_d[7:0] = ctrl_b_q;
                RPD_OFS_STATUS: rdata_d[3:0] = {state_q == RPD_ST_SAMPLE, capture_q};
                RPD_OFS_EXPECT: rdata_d[2:0] = expect_q;
                RPD_OFS_DELAY:  rdata_d[7:0] = delay_q;
                RPD_OFS_EMG:    rdata_d[2:0] = {emg_s, emergency_stop_active, emg_en_q};
                RPD_OFS_ROTOR:  ;
                default:        rresp_d = RPD_RESP_SLVERR;
            endcase
        end
    end

    // Bus and configuration registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_q  <= rpd_ctrl_a_t'(RPD_RST_CTRL_A);
            ctrl_b_q  <= rpd_ctrl_b_t'(RPD_RST_CTRL_B);
            expect_q  <= RPD_RST_EXPECT;
            delay_q   <= RPD_RST_DELAY;
            emg_en_q  <= RPD_RST_EMG_EN;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wdat_q    <= 32'h0000_0000;
            wlane_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RPD_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RPD_RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else begin
            ctrl_a_q  <= ctrl_a_d;
            ctrl_b_q  <= ctrl_b_d;
            expect_q  <= expect_d;
            delay_q   <= delay_d;
            emg_en_q  <= emg_en_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            waddr_q   <= waddr_d;
            wdat_q    <= wdat_d;
            wlane_q   <= wlane_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;

    // ****************************************************************
    // Sampling delay after turn-on, one counter per low side and one for PWM.
    // ****************************************************************
    logic       pwm_on;
    logic [3:0] dly_src, dly_done;
    assign pwm_on  = |pwm_phase_on;
    assign dly_src = {pwm_on, low_side_on};

    // A counter starts at each turn-on, so noise right after switching is not sampled.
    for (genvar g = 0; g < 4; g++) begin : g_dly
        logic [7:0] cnt_q, cnt_d;
        always_comb begin
            cnt_d = 8'h00;
            if (dly_src[g]) cnt_d = (cnt_q == delay_q) ? cnt_q : cnt_q + 8'd1;
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) cnt_q <= 8'h00;
            else cnt_q <= cnt_d;
        end
        assign dly_done[g] = dly_src[g] && (cnt_q == delay_q);
    end

    // ****************************************************************
    // Detection sequencer.
    // ****************************************************************
    logic [4:0] tick_q, tick_d;
    logic [2:0] held_q, held_d, gate, now_v, mask;
    logic [3:0] cnt_q, cnt_d;
    logic       pwm_q, pdi_q, pdi_d, emg_q, emg_d;
    logic       tick, start, stop, cond, samp, detect;

    // Per-phase sampling gate for the selected mode.
    always_comb begin
        unique case (ctrl_b_q.spl_mode)
            RPD_SPL_CONT:    gate = 3'h7;
            RPD_SPL_LOWSIDE: gate = dly_done[2:0];
            default:         gate = {3{dly_done[3]}};
        endcase
    end

    // Idle phases keep their last level while active ones refresh.
    always_comb begin
        tick_d   = (tick_q == RPD_SPL_LAST[ctrl_b_q.period_sel]) ? 5'h00 : tick_q + 5'd1;
        tick     = (tick_q == RPD_SPL_LAST[ctrl_b_q.period_sel]);
        mask     = ctrl_a_q.one_pin ? 3'h4 : 3'h7;
        samp     = (state_q == RPD_ST_SAMPLE) && tick && (|gate);
        now_v    = (gate & pos_s) | (~gate & held_q);
        cond     = ctrl_a_q.unmatch_mode ? (((now_v ^ capture_q) & mask) != 3'h0)
                                         : (((now_v ^ expect_q) & mask) == 3'h0);
        detect   = samp && cond && (({1'b0, cnt_q} + 5'd1) >= {1'b0, ctrl_b_q.match_cnt});
        emg_d    = (emg_q && !(emg_clr && emg_s)) || (emg_en_q && !emg_s);
        // Enable comes from the next value, so one write can enable and start together.
        start    = ctrl_a_d.enable && !emg_d
                   && (sw_start || (ctrl_a_q.tmr2_start_en && timer2_event));
        stop     = sw_stop || (ctrl_a_q.tmr3_stop_en && timer3_event);
        state_d  = state_q;
        capture_d = capture_q;
        held_d   = held_q;
        cnt_d    = cnt_q;
        pdi_d    = 1'b0;
        unique case (state_q)
            RPD_ST_IDLE: begin
                if (start) begin
                    state_d   = RPD_ST_SAMPLE;
                    capture_d = pos_s;
                    held_d    = pos_s;
                    cnt_d     = 4'h0;
                end
            end
            RPD_ST_SAMPLE: begin
                if (samp) begin
                    held_d = now_v;
                    cnt_d  = cond ? cnt_q + 4'd1 : 4'h0;
                end
                if (ctrl_a_q.recount_en && ctrl_b_q.spl_mode != RPD_SPL_CONT
                    && pwm_q && !pwm_on) begin
                    cnt_d = 4'h0;
                end
                if (detect) begin
                    pdi_d   = 1'b1;
                    state_d = RPD_ST_IDLE;
                end else if (stop || !ctrl_a_q.enable || emg_d) begin
                    state_d = RPD_ST_IDLE;
                end
            end
            default: state_d = RPD_ST_IDLE;
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= RPD_ST_IDLE;
            tick_q    <= 5'h00;
            capture_q <= 3'h0;
            held_q    <= 3'h0;
            cnt_q     <= 4'h0;
            pwm_q     <= 1'b0;
            pdi_q     <= 1'b0;
            emg_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            tick_q    <= tick_d;
            capture_q <= capture_d;
            held_q    <= held_d;
            cnt_q     <= cnt_d;
            pwm_q     <= pwm_on;
            pdi_q     <= pdi_d;
            emg_q     <= emg_d;
        end
    end

    assign position_detect_interrupt = pdi_q;
    assign emergency_stop_active     = emg_q;
    assign sampling_active           = state_q[1];  // One-hot bit of the sampling state.

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_detect_ends_sampling: assert property (pdi_q |-> state_q == RPD_ST_IDLE)
        else $error("detect pulse while still sampling");
    a_start_capture: assert property (state_q == RPD_ST_IDLE && start |=>
        state_q == RPD_ST_SAMPLE && capture_q == $past(pos_s))
        else $error("start state not captured");
    a_status_capture: assert property (arvalid && arready_q && araddr == RPD_OFS_STATUS
        |=> rvalid_q && rdata_q[2:0] == $past(capture_q))
        else $error("status read lost start state");
    a_timer_stop: assert property (state_q == RPD_ST_SAMPLE && ctrl_a_q.tmr3_stop_en
        && timer3_event |=> state_q == RPD_ST_IDLE)
        else $error("timer 3 did not stop sampling");
    a_idle_phase_hold: assert property (state_q == RPD_ST_SAMPLE
        && ctrl_b_q.spl_mode == RPD_SPL_LOWSIDE && !gate[2] |=> $stable(held_q[2]))
        else $error("idle phase sample changed");
    a_delay_blocks: assert property (ctrl_b_q.spl_mode == RPD_SPL_PWMON
        && pwm_on && !pwm_q && delay_q > 8'h01 |-> gate == 3'h0 ##1 !samp)
        else $error("sampled inside turn-on delay");
    a_recount_clear: assert property (state_q == RPD_ST_SAMPLE && ctrl_a_q.recount_en
        && ctrl_b_q.spl_mode != RPD_SPL_CONT && pwm_q && !pwm_on && !detect
        |=> cnt_q == 4'h0)
        else $error("match count kept across PWM off");
    a_count_needed: assert property (pdi_q && ctrl_b_q.match_cnt > 4'd1
        |-> $past(cnt_q) != 4'h0)
        else $error("detect before enough samples");
    a_emg_halts: assert property (emg_en_q && !emg_s |=> emg_q ##0 state_q == RPD_ST_IDLE)
        else $error("emergency did not halt sampling");

    c_match_detect:   cover property (pdi_q && !ctrl_a_q.unmatch_mode);
    c_unmatch_detect: cover property (pdi_q && ctrl_a_q.unmatch_mode);
    c_lowside_detect: cover property (pdi_q && ctrl_b_q.spl_mode == RPD_SPL_LOWSIDE);

endmodule : rpd_detector

//--- core/rpd_pkg.sv
// Shared constants and types of the rotor position detector.
// Assumes a single 125 MHz clock and an AXI4-Lite register port with 8-bit addresses.
package rpd_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [7:0] RPD_OFS_CTRL_A  = 8'h00;
    localparam logic [7:0] RPD_OFS_CTRL_B  = 8'h04;
    localparam logic [7:0] RPD_OFS_STATUS  = 8'h08;
    localparam logic [7:0] RPD_OFS_EXPECT  = 8'h0C;
    localparam logic [7:0] RPD_OFS_DELAY   = 8'h10;
    localparam logic [7:0] RPD_OFS_EMG     = 8'h14;
    localparam logic [7:0] RPD_OFS_ROTOR   = 8'h18;

    // Bit positions of the write-only strobes and emergency fields.
    localparam int unsigned RPD_BIT_SW_STOP  = 7;
    localparam int unsigned RPD_BIT_SW_START = 6;
    localparam int unsigned RPD_BIT_EMG_EN   = 0;
    localparam int unsigned RPD_BIT_EMG_CLR  = 1;

    // Values after reset.
    localparam logic [5:0] RPD_RST_CTRL_A  = 6'h00;
    localparam logic [7:0] RPD_RST_CTRL_B  = 8'h00;
    localparam logic [2:0] RPD_RST_EXPECT  = 3'h0;
    localparam logic [7:0] RPD_RST_DELAY   = 8'h00;
    localparam logic       RPD_RST_EMG_EN  = 1'b1;

    // AXI responses.
    localparam logic [1:0] RPD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RPD_RESP_SLVERR = 2'h2;

    // Sampling modes.
    localparam logic [1:0] RPD_SPL_PWMON   = 2'h0;
    localparam logic [1:0] RPD_SPL_CONT    = 2'h1;
    localparam logic [1:0] RPD_SPL_LOWSIDE = 2'h2;

    // Last count of the sample tick divider for periods of 4, 8, 16 and 32 clocks.
    localparam logic [4:0] RPD_SPL_LAST [0:3] = '{5'h03, 5'h07, 5'h0F, 5'h1F};

    // Expected {U,V,W} levels for rotor modes 0 to 5.
    localparam logic [2:0] RPD_PATTERN [0:5] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

    // Control word A, bits 5 to 0 of its register.
    typedef struct packed {
        logic tmr3_stop_en;
        logic tmr2_start_en;
        logic one_pin;
        logic recount_en;
        logic unmatch_mode;
        logic enable;
    } rpd_ctrl_a_t;

    // Control word B, bits 7 to 0 of its register.
    typedef struct packed {
        logic [1:0] period_sel;
        logic [1:0] spl_mode;
        logic [3:0] match_cnt;
    } rpd_ctrl_b_t;

    typedef enum logic [1:0] {
        RPD_ST_IDLE   = 2'b01,
        RPD_ST_SAMPLE = 2'b10
    } rpd_state_t;

endpackage : rpd_pkg

//--- core/rpd_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin inputs and the block clock aclk.
`timescale 1ns/1ps
module rpd_sync3 #(
    parameter int unsigned       WIDTH   = 4,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    input  wire logic             aclk,     // Block clock.
    input  wire logic             aresetn,  // Synchronous reset, active low.
    input  wire logic [WIDTH-1:0] pin_in,   // Raw asynchronous levels.
    output logic      [WIDTH-1:0] sync_out  // Filtered synchronous levels.
);

    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] out_d;

    // A change counts only once stages two and three agree; stage one feeds stage two alone.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end

    // Shift stages.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule : rpd_sync3

//--- bench/rpd_pos_model.sv
// Position sensor model: three winding comparator or Hall levels.
// Assumes the bench sets the wanted {U,V,W} levels on aclk.
`timescale 1ns/1ps
module rpd_pos_model #(
    parameter int unsigned LAG = 2
) (
    input  wire logic       aclk,     // Block clock.
    input  wire logic [2:0] lvl_cmd,  // Wanted {U,V,W} levels.
    output logic      [2:0] lvl_pin   // Levels seen on the position pins.
);
    logic [2:0] lag_q [LAG] = '{default: 3'h0};

    // A real comparator settles late, so new levels reach the pins LAG clocks later.
    always_ff @(posedge aclk) begin
        lag_q[0] <= lvl_cmd;
        for (int i = 1; i < LAG; i++) begin
            lag_q[i] <= lag_q[i-1];
        end
    end
    // The detector only reads these pins, as software keeps them set as inputs.
    assign lvl_pin = lag_q[LAG-1];
endmodule : rpd_pos_model

//--- bench/rotor_position_detector_tb_top.sv
// Self-checking bench of the rotor position detector.
// Assumes the detector and the position sensor model on one 125 MHz clock.
`timescale 1ns/1ps
module rotor_position_detector_tb_top import rpd_pkg::*;;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, timer2_event = 0, timer3_event = 0;
    logic        emergency_stop_input = 1, awready, wready, bvalid, arready, rvalid, seen;
    logic        position_detect_interrupt, emergency_stop_active, sampling_active;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, got;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, rsp, wrsp;
    logic [2:0]  lvl_cmd = '0, pins, pwm_phase_on = '0, low_side_on = '0;
    logic [7:0]  rows [6] = '{8'h05, 8'h14, 8'h26, 8'h32, 8'h43, 8'h51};
    int          n_errors = 0, num_checks = 0, cyc = 0;

    rpd_pos_model SENS (.aclk, .lvl_cmd, .lvl_pin(pins));
    rpd_detector DUT (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .phase_u_position_input(pins[2]), .phase_v_position_input(pins[1]),
        .phase_w_position_input(pins[0]), .emergency_stop_input, .timer2_event,
        .timer3_event, .pwm_phase_on, .low_side_on, .position_detect_interrupt,
        .emergency_stop_active, .sampling_active
    );

    // Clock, and a ceiling well above the several hundred cycles the tests need.
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic chkb(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask : chkb

    // Both write channels are offered together and each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ad = 0, wd = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        wrsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rd

    // Waits at most n cycles for the detect pulse.
    task automatic wait_irq(input int n);
        seen = 1'b0;
        for (int i = 0; i < n && seen !== 1'b1; i++) begin
            @(posedge aclk);
            seen = position_detect_interrupt;
        end
    endtask : wait_irq

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // Reset value and bad-address checks first, then the rotor mode table, then the hand-written cases.
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(RPD_OFS_EMG, got);
        chk(got, 32'h0000_0005);
        rd(8'h1C, got);
        chk({30'h0, rsp}, {30'h0, RPD_RESP_SLVERR});
        wr(8'h1C, 32'h0000_0000);
        chk({30'h0, wrsp}, {30'h0, RPD_RESP_SLVERR});
        for (int i = 0; i < 6; i++) begin
            wr(RPD_OFS_ROTOR, {28'h0, rows[i][7:4]});
            rd(RPD_OFS_EXPECT, got);
            chk(got, {29'h0, rows[i][2:0]});
        end
        lvl_cmd <= 3'h4;
        wr(RPD_OFS_CTRL_B, 32'h0000_0013);
        wr(RPD_OFS_CTRL_A, 32'h0000_0041);
        wait_irq(100);
        chkb(seen, 1'b0);
        chkb(sampling_active, 1'b1);
        lvl_cmd <= 3'h1;
        wait_irq(40);
        chkb(seen, 1'b1);
        chkb(sampling_active, 1'b0);
        wr(RPD_OFS_CTRL_A, 32'h0000_0043);
        rd(RPD_OFS_STATUS, got);
        chk(got, 32'h0000_0009);
        wait_irq(60);
        chkb(seen, 1'b0);
        lvl_cmd <= 3'h3;
        wait_irq(60);
        chkb(seen, 1'b1);
        wr(RPD_OFS_CTRL_A, 32'h0000_0031);
        timer2_event <= 1'b1;
        @(posedge aclk);
        timer2_event <= 1'b0;
        repeat (2) @(posedge aclk);
        chkb(sampling_active, 1'b1);
        timer3_event <= 1'b1;
        @(posedge aclk);
        timer3_event <= 1'b0;
        repeat (2) @(posedge aclk);
        chkb(sampling_active, 1'b0);
        lvl_cmd <= 3'h1;
        wr(RPD_OFS_CTRL_B, 32'h0000_0001);
        wr(RPD_OFS_DELAY, 32'h0000_001E);
        wr(RPD_OFS_CTRL_A, 32'h0000_0041);
        wait_irq(60);
        chkb(seen, 1'b0);
        pwm_phase_on <= 3'h7;
        wait_irq(20);
        chkb(seen, 1'b0);
        wait_irq(40);
        chkb(seen, 1'b1);
        emergency_stop_input <= 1'b0;
        repeat (8) @(posedge aclk);
        chkb(emergency_stop_active, 1'b1);
        emergency_stop_input <= 1'b1;
        lvl_cmd <= 3'h0;
        repeat (6) @(posedge aclk);
        wr(RPD_OFS_EMG, 32'h0000_0002);
        rd(RPD_OFS_EMG, got);
        chk(got, 32'h0000_0004);
        wr(RPD_OFS_CTRL_B, 32'h0000_0021);
        wr(RPD_OFS_CTRL_A, 32'h0000_0045);
        low_side_on <= 3'h1;
        wait_irq(50);
        chkb(seen, 1'b0);
        lvl_cmd <= 3'h7;
        wait_irq(20);
        chkb(seen, 1'b1);
        wr(RPD_OFS_CTRL_A, 32'h0000_0000);
        rd(RPD_OFS_CTRL_A, got);
        chk(got, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : rotor_position_detector_tb_top
